// ---- hw/rdv_cfg.svh ----
`ifndef RDV_CFG_SVH
`define RDV_CFG_SVH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define RDV_IDX_CONFIG 4'h0
`define RDV_IDX_ON 4'h4
`define RDV_IDX_OFF 4'h5
`define RDV_IDX_LOW 4'h6
`define RDV_IDX_HIGH 4'h7
`define RDV_IDX_LEVEL 4'h8
`define RDV_IDX_CTRL 4'h9
`define RDV_IDX_STATUS 4'ha
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RDV_BIT_SLICER 15
`define RDV_BIT_CONT 5
`define RDV_BIT_SINGLE 6
`define RDV_BIT_RX_EN 0
`define RDV_BIT_POLL_EN 1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RDV_RST_CONFIG 16'h0000
`define RDV_RST_ON 16'hfebf
`define RDV_RST_OFF 16'hf37f
`define RDV_RST_LOW 12'h000
`define RDV_RST_HIGH 12'h001
`define RDV_RST_LEVEL 6'h3f
// ----------------------------------------
// Timing
// ----------------------------------------
`define RDV_CLK_HZ 25000000
`define RDV_SETTLE_US 2600
`define RDV_SETTLE_CYC ((`RDV_CLK_HZ / 1000) * `RDV_SETTLE_US / 1000)
`define RDV_PERIODS 3
`endif

// ---- hw/rdv_pkg.sv ----
package rdv_pkg;
  typedef enum logic [1:0] {
    RDV_IDLE,
    RDV_ON,
    RDV_OFF
  } rdv_poll_t;
  typedef enum logic [1:0] {
    RDV_WAIT_RISE,
    RDV_HIGH,
    RDV_LOW
  } rdv_meas_t;
endpackage

// ---- hw/rdv_core.sv ----
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns
`include "rdv_cfg.svh"
// Operation
// - Config bit 15 picks integrator or peaks
// - Peak detectors stay active whichever slicer is chosen
// - Peaks enabled only once receive path active
// - Peaks off: positive low, negative high
// - Valid needs rate window and strength
// - Continuous and single-shot modes, bits 5,6; code reads only bit 6, bit 5 has no effect
// - Detection enabled 2.6 ms after receive on
// - Window-complete edge latches strength compare
// - Ready again after three data periods
// - Window counter measures data high time
// - Accept one or two high times
// - Decision spans three full data periods
// - Window counter runs at quarter clock
// - Rate limits 12 bits at 6 and 7
// - Limits reset zero and one, window live
// - Strength limit 6 bits at 8
// - Strength limit resets all ones, disabled
// - Poll durations 16 bits, on resets 65215
// - Valid during on period fires wake pulse
module rdv_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sliced_data,
  input wire logic rc_tick,
  input wire logic rx_path_ready,
  input wire logic [5:0] strength_level,
  output logic lowpass_integrator_choice,
  output logic peak_enable,
  output logic peak_pos_force_low,
  output logic peak_neg_force_high,
  output logic receive_on,
  output logic data_valid,
  output logic wake_pulse_output
);
  localparam int SETTLE_CYC = `RDV_SETTLE_CYC;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0] general_config;
  logic [15:0] poll_on_duration;
  logic [15:0] poll_off_duration;
  logic [11:0] rate_window_low_limit;
  logic [11:0] rate_window_high_limit;
  logic [5:0] signal_level_limit;
  logic [1:0] control;
  logic done;
  logic det_enable;
  logic valid_event;
  rdv_pkg::rdv_poll_t poll_state;

  // Every access answers on its second cycle
  logic next_done;
  assign next_done = (avs_read | avs_write) & ~done;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else begin
      done <= next_done;
    end
  end

  // Registered copy keeps the bus output free of glitches
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~next_done;
    end
  end

  wire wr_go = avs_write & done & avs_address[1:0] == 2'b00;
  wire [3:0] idx = avs_address[5:2];
  wire [15:0] wd = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                    avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};
  wire [1:0] be = avs_byteenable[1:0];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] b);
    merge = {b[1] ? nw[15:8] : old[15:8], b[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Merged images, cut to each register's width below
  wire [15:0] merged_low = merge({4'h0, rate_window_low_limit}, wd, be);
  wire [15:0] merged_high = merge({4'h0, rate_window_high_limit}, wd, be);
  wire [15:0] merged_level = merge({10'h000, signal_level_limit}, wd, be);
  wire [15:0] merged_ctrl = merge({14'h0000, control}, wd, be);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      general_config <= `RDV_RST_CONFIG;
      poll_on_duration <= `RDV_RST_ON;
      poll_off_duration <= `RDV_RST_OFF;
      rate_window_low_limit <= `RDV_RST_LOW;
      rate_window_high_limit <= `RDV_RST_HIGH;
      signal_level_limit <= `RDV_RST_LEVEL;
      control <= 2'h0;
    end else if (wr_go) begin
      unique case (idx)
        `RDV_IDX_CONFIG: general_config <= merge(general_config, wd, be);
        `RDV_IDX_ON: poll_on_duration <= merge(poll_on_duration, wd, be);
        `RDV_IDX_OFF: poll_off_duration <= merge(poll_off_duration, wd, be);
        `RDV_IDX_LOW: rate_window_low_limit <= merged_low[11:0];
        `RDV_IDX_HIGH: rate_window_high_limit <= merged_high[11:0];
        `RDV_IDX_LEVEL: signal_level_limit <= merged_level[5:0];
        `RDV_IDX_CTRL: control <= merged_ctrl[1:0];
        default: ;
      endcase
    end
  end

  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (idx)
      `RDV_IDX_CONFIG: next_rdata = {16'h0000, general_config};
      `RDV_IDX_ON: next_rdata = {16'h0000, poll_on_duration};
      `RDV_IDX_OFF: next_rdata = {16'h0000, poll_off_duration};
      `RDV_IDX_LOW: next_rdata = {20'h00000, rate_window_low_limit};
      `RDV_IDX_HIGH: next_rdata = {20'h00000, rate_window_high_limit};
      `RDV_IDX_LEVEL: next_rdata = {26'h0000000, signal_level_limit};
      `RDV_IDX_CTRL: next_rdata = {30'h00000000, control};
      `RDV_IDX_STATUS: next_rdata = {26'h0000000, poll_state == rdv_pkg::RDV_OFF,
                                     poll_state == rdv_pkg::RDV_ON, peak_enable,
                                     det_enable, receive_on, data_valid};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~done) begin
      avs_readdata <= avs_address[1:0] == 2'b00 ? next_rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Pin synchronisers (three stages, 2nd/3rd agree)
  // ----------------------------------------
  logic [2:0] s_data;
  logic [2:0] s_tick;
  logic [2:0] s_path;
  logic data_f;
  logic tick_f;
  logic tick_prev;
  logic path_f;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_data <= 3'h0;
      s_tick <= 3'h0;
      s_path <= 3'h0;
      data_f <= 1'b0;
      tick_f <= 1'b0;
      tick_prev <= 1'b0;
      path_f <= 1'b0;
    end else begin
      s_data <= {s_data[1:0], sliced_data};
      s_tick <= {s_tick[1:0], rc_tick};
      s_path <= {s_path[1:0], rx_path_ready};
      if (s_data[1] == s_data[2]) data_f <= s_data[2];
      if (s_tick[1] == s_tick[2]) tick_f <= s_tick[2];
      if (s_path[1] == s_path[2]) path_f <= s_path[2];
      tick_prev <= tick_f;
    end
  end
  wire rc_step = tick_f & ~tick_prev;

  // ----------------------------------------
  // Self-polling sequencer
  // ----------------------------------------
  // Counts up to all ones, so a larger value gives a shorter period
  logic [15:0] poll_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      poll_state <= rdv_pkg::RDV_IDLE;
      poll_cnt <= 16'h0000;
    end else if (!control[`RDV_BIT_POLL_EN]) begin
      poll_state <= rdv_pkg::RDV_IDLE;
      poll_cnt <= poll_on_duration;
    end else begin
      unique case (poll_state)
        rdv_pkg::RDV_IDLE: begin
          poll_state <= rdv_pkg::RDV_ON;
          poll_cnt <= poll_on_duration;
        end
        rdv_pkg::RDV_ON: if (rc_step) begin
          if (poll_cnt == 16'hffff) begin
            poll_state <= rdv_pkg::RDV_OFF;
            poll_cnt <= poll_off_duration;
          end else begin
            poll_cnt <= poll_cnt + 16'h0001;
          end
        end
        rdv_pkg::RDV_OFF: if (rc_step) begin
          if (poll_cnt == 16'hffff) begin
            poll_state <= rdv_pkg::RDV_ON;
            poll_cnt <= poll_on_duration;
          end else begin
            poll_cnt <= poll_cnt + 16'h0001;
          end
        end
        default: poll_state <= rdv_pkg::RDV_IDLE;
      endcase
    end
  end

  wire rx_active = control[`RDV_BIT_RX_EN] | (poll_state == rdv_pkg::RDV_ON);

  // Settle timer gates detection after receive starts
  logic [16:0] settle_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_cnt <= 17'h00000;
      det_enable <= 1'b0;
    end else if (!rx_active) begin
      settle_cnt <= 17'h00000;
      det_enable <= 1'b0;
    end else if (settle_cnt == 17'(SETTLE_CYC - 1)) begin
      det_enable <= 1'b1;
    end else begin
      settle_cnt <= settle_cnt + 17'h00001;
    end
  end

  // ----------------------------------------
  // Power sequencer outputs
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      receive_on <= 1'b0;
    end else begin
      receive_on <= rx_active;
    end
  end

  // Peaks wait for the whole path, avoiding a bogus threshold
  logic peaks_allowed;
  assign peaks_allowed = rx_active & path_f;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      peak_enable <= 1'b0;
      peak_pos_force_low <= 1'b1;
      peak_neg_force_high <= 1'b1;
    end else begin
      peak_enable <= peaks_allowed;
      peak_pos_force_low <= ~peaks_allowed;
      peak_neg_force_high <= ~peaks_allowed;
    end
  end

  // Selection only steers the slicer; peaks run regardless
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowpass_integrator_choice <= 1'b1;
    end else begin
      lowpass_integrator_choice <= ~general_config[`RDV_BIT_SLICER];
    end
  end

  // ----------------------------------------
  // Window counter and decision
  // ----------------------------------------
  logic [1:0] div4;
  logic [11:0] win_cnt;
  logic data_prev;
  logic [1:0] good_periods;
  logic [1:0] span;
  logic single_done;
  logic win_done;
  logic win_done_prev;
  logic strength_ok;
  logic rate_ok;
  rdv_pkg::rdv_meas_t meas;
  wire quarter = div4 == 2'h3;
  wire in_lim1 = win_cnt >= rate_window_low_limit && win_cnt <= rate_window_high_limit;
  wire [12:0] twice_lo = {rate_window_low_limit, 1'b0};
  wire [12:0] twice_hi = {rate_window_high_limit, 1'b0};
  wire in_lim2 = {1'b0, win_cnt} >= twice_lo && {1'b0, win_cnt} <= twice_hi;
  wire window_live = rate_window_high_limit > rate_window_low_limit;
  wire single_mode = general_config[`RDV_BIT_SINGLE];
  wire run = det_enable & window_live & ~(single_mode & single_done);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div4 <= 2'h0;
      win_cnt <= 12'h000;
      data_prev <= 1'b0;
      good_periods <= 2'h0;
      span <= 2'h0;
      win_done <= 1'b0;
      rate_ok <= 1'b0;
      meas <= rdv_pkg::RDV_WAIT_RISE;
    end else begin
      data_prev <= data_f;
      div4 <= div4 + 2'h1;
      win_done <= 1'b0;
      if (!run) begin
        meas <= rdv_pkg::RDV_WAIT_RISE;
        good_periods <= 2'h0;
        span <= 2'h0;
        win_cnt <= 12'h000;
      end else begin
        unique case (meas)
          rdv_pkg::RDV_WAIT_RISE: if (data_f & ~data_prev) begin
            meas <= rdv_pkg::RDV_HIGH;
            win_cnt <= 12'h000;
          end
          rdv_pkg::RDV_HIGH: begin
            if (quarter && win_cnt != 12'hfff) win_cnt <= win_cnt + 12'h001;
            if (~data_f) meas <= rdv_pkg::RDV_LOW;
          end
          rdv_pkg::RDV_LOW: if (data_f) begin
            // One period done; three make a decision
            meas <= rdv_pkg::RDV_HIGH;
            win_cnt <= 12'h000;
            if (span == 2'(`RDV_PERIODS - 1)) begin
              win_done <= 1'b1;
              rate_ok <= (good_periods + 2'((in_lim1 | in_lim2) ? 1 : 0))
                         == 2'(`RDV_PERIODS);
              span <= 2'h0;
              good_periods <= 2'h0;
            end else begin
              span <= span + 2'h1;
              good_periods <= good_periods + 2'((in_lim1 | in_lim2) ? 1 : 0);
            end
          end
          default: meas <= rdv_pkg::RDV_WAIT_RISE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Decision flag and wake pulse
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      win_done_prev <= 1'b0;
      strength_ok <= 1'b0;
      data_valid <= 1'b0;
      single_done <= 1'b0;
      valid_event <= 1'b0;
      wake_pulse_output <= 1'b0;
    end else begin
      win_done_prev <= win_done;
      valid_event <= 1'b0;
      if (!det_enable) begin
        single_done <= 1'b0;
        data_valid <= 1'b0;
      end
      if (win_done & ~win_done_prev) begin
        // All-ones limit means strength is never met
        strength_ok <= signal_level_limit != 6'h3f
                       && strength_level >= signal_level_limit;
      end
      if (win_done_prev) begin
        data_valid <= rate_ok & strength_ok;
        valid_event <= rate_ok & strength_ok;
        single_done <= single_mode;
      end
      wake_pulse_output <= valid_event & (poll_state == rdv_pkg::RDV_ON);
    end
  end
endmodule

// ---- verification/rdv_props.sv ----
`timescale 1ns/1ns
module rdv_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic lowpass_integrator_choice,
  input wire logic peak_enable,
  input wire logic peak_pos_force_low,
  input wire logic peak_neg_force_high,
  input wire logic receive_on,
  input wire logic data_valid,
  input wire logic wake_pulse_output
);
  // ----
  // Checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_answer_next_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("access not answered next cycle");
  a_answer_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_answer_has_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_peaks_need_rx: assert property (peak_enable |-> receive_on)
    else $error("peaks on without receive");
  a_pos_tied_off: assert property (peak_pos_force_low == !peak_enable)
    else $error("positive peak force wrong");
  a_neg_tied_off: assert property (peak_neg_force_high == peak_pos_force_low)
    else $error("negative peak force wrong");
  a_slicer_by_write: assert property ($changed(lowpass_integrator_choice)
    |-> $past(avs_write, 1) || $past(avs_write, 2)) else $error("slicer choice moved alone");
  a_wake_single: assert property (wake_pulse_output |=> !wake_pulse_output)
    else $error("wake pulse too long");
  a_wake_in_rx: assert property (wake_pulse_output |-> receive_on)
    else $error("wake outside receive");
  a_valid_in_rx: assert property ($rose(data_valid) |-> receive_on)
    else $error("valid raised outside receive");
  cover property ($rose(data_valid));
  cover property ($rose(peak_enable));
  cover property (avs_write && !avs_waitrequest);
  cover property (wake_pulse_output);
endmodule
bind rdv_core rdv_props u_props (.clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
  .lowpass_integrator_choice, .peak_enable, .peak_pos_force_low, .peak_neg_force_high,
  .receive_on, .data_valid, .wake_pulse_output);

// ---- verification/rdv_far.sv ----
`timescale 1ns/1ns
module rdv_far (
  input wire logic clk,
  input wire logic [9:0] hi_time,
  input wire logic wake_pulse_output,
  output logic sliced_data,
  output logic rc_tick,
  output logic [7:0] wakes
);
  // ----
  // Square data and free RC tick
  // ----
  logic [10:0] ph = 11'h0;
  logic [4:0] rc = 5'h0;
  logic data_q = 1'b0;
  logic tick_q = 1'b0;
  logic [7:0] wake_cnt = 8'h0;
  assign sliced_data = data_q;
  assign rc_tick = tick_q;
  assign wakes = wake_cnt;
  always @(posedge clk) begin
    ph <= (ph >= {hi_time, 1'b0} - 11'h1) ? 11'h0 : ph + 11'h1;
    data_q <= ph < {1'b0, hi_time};
    rc <= rc + 5'h1;
    tick_q <= rc[4];
    if (wake_pulse_output) wake_cnt <= wake_cnt + 8'h1;
  end
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] avs_address = 6'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, sliced_data, rc_tick;
  logic rx_path_ready = 1'b1;
  logic [5:0] strength_level = 6'h30;
  logic [9:0] hi_time = 10'h050;
  logic lowpass_integrator_choice, peak_enable, peak_pos_force_low, peak_neg_force_high;
  logic receive_on, data_valid, wake_pulse_output;
  logic [7:0] wakes;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  rdv_core dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .sliced_data, .rc_tick, .rx_path_ready,
    .strength_level, .lowpass_integrator_choice, .peak_enable, .peak_pos_force_low,
    .peak_neg_force_high, .receive_on, .data_valid, .wake_pulse_output);
  rdv_far u_far (.clk, .hi_time, .wake_pulse_output, .sliced_data, .rc_tick, .wakes);
  // ----
  // Shared tasks
  // ----
  task automatic complete_run();
    $display("Compared %0d, mismatched %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Held until waitrequest is seen low; an idle edge follows each access
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_byteenable <= 4'h3;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [3:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(rd, e);
  endtask
  task automatic await_valid(input logic v, input int lim);
    int n;
    n = 0;
    while (data_valid !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(data_valid, v);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset_values();
    logic [3:0] idx [6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    logic [31:0] e [6] = '{32'h0, 32'hfebf, 32'hf37f, 32'h0, 32'h1, 32'h3f};
    for (int i = 0; i < 6; i++) begin
      rdchk(idx[i], e[i]);
    end
    chk({lowpass_integrator_choice, peak_enable, peak_pos_force_low, peak_neg_force_high},
      4'b1011);
  endtask
  task automatic t_registers();
    bus(1'b1, 4'h0, 32'h8000);
    rdchk(4'h0, 32'h8000);
    chk(lowpass_integrator_choice, 1'b0);
    bus(1'b1, 4'h7, 32'hffff);
    rdchk(4'h7, 32'hfff);
    bus(1'b1, 4'h8, 32'hffff);
    rdchk(4'h8, 32'h3f);
    bus(1'b1, 4'hb, 32'h1234);
    rdchk(4'hb, 32'h0);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h6, 32'h00a);
    bus(1'b1, 4'h7, 32'h01e);
    bus(1'b1, 4'h8, 32'h01a);
    rdchk(4'h6, 32'h00a);
    chk(lowpass_integrator_choice, 1'b1);
  endtask
  // Only one settle fits the run, so all detection cases share it
  task automatic t_detect();
    bus(1'b1, 4'h9, 32'h1);
    repeat (20) @(posedge clk);
    chk({receive_on, peak_enable, peak_pos_force_low, peak_neg_force_high}, 4'b1100);
    bus(1'b1, 4'h0, 32'h8000);
    repeat (2) @(posedge clk);
    chk({lowpass_integrator_choice, peak_enable}, 2'b01);
    repeat (60000) @(posedge clk);
    chk(data_valid, 1'b0);
    await_valid(1'b1, 8000);
    strength_level <= 6'h05;
    await_valid(1'b0, 3000);
    strength_level <= 6'h30;
    await_valid(1'b1, 3000);
    hi_time <= 10'h12c;
    await_valid(1'b0, 3000);
    hi_time <= 10'h0a0;
    await_valid(1'b1, 3000);
    hi_time <= 10'h014;
    await_valid(1'b0, 3000);
    chk(wakes, 8'h0);
  endtask
  // Polling on top of the running receiver keeps the settled detector
  task automatic t_polling();
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h5, 32'h0);
    bus(1'b1, 4'h9, 32'h3);
    hi_time <= 10'h050;
    await_valid(1'b1, 3000);
    repeat (4) @(posedge clk);
    chk(wakes, 8'h1);
    rdchk(4'ha, 32'h1f);
    bus(1'b1, 4'h4, 32'hffff);
    bus(1'b1, 4'h9, 32'h1);
    bus(1'b1, 4'h9, 32'h3);
    repeat (100) @(posedge clk);
    rdchk(4'ha, 32'h2f);
    repeat (1000) @(posedge clk);
    chk(wakes, 8'h1);
    bus(1'b1, 4'h8, 32'h3f);
    await_valid(1'b0, 3000);
    bus(1'b1, 4'h8, 32'h1a);
    await_valid(1'b1, 3000);
    bus(1'b1, 4'h0, 32'h8040);
    repeat (600) @(posedge clk);
    strength_level <= 6'h05;
    repeat (1500) @(posedge clk);
    chk(data_valid, 1'b1);
    rx_path_ready <= 1'b0;
    repeat (10) @(posedge clk);
    chk({receive_on, peak_enable, peak_pos_force_low, peak_neg_force_high}, 4'b1011);
    rx_path_ready <= 1'b1;
    bus(1'b1, 4'h9, 32'h0);
    repeat (20) @(posedge clk);
    chk({peak_enable, peak_pos_force_low, peak_neg_force_high}, 3'b011);
    chk(wakes, 8'h1);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_registers();
    t_detect();
    t_polling();
    complete_run();
  end
endmodule
